/* File: hdl/can_diag_pkg.sv */
// Constants and types shared by the CAN cycle diagnostics block
package can_diag_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLOCK_HZ     = 40_000_000;
  localparam int          NS_PER_S     = 1_000_000_000;
  localparam logic [31:0] NS_PER_CYCLE = 32'(NS_PER_S / CLOCK_HZ);

  // ****************************************
  // Object indices and subindices
  // ****************************************
  localparam logic [15:0] IDX_STATUS   = 16'hf108;
  localparam logic [15:0] IDX_DIAG     = 16'hf120;
  localparam logic [15:0] IDX_CTRL     = 16'hf200;

  localparam logic [7:0]  SUB_RX_CNT   = 8'h21;
  localparam logic [7:0]  SUB_TX_CNT   = 8'h22;
  localparam logic [7:0]  SUB_SYNC_T   = 8'h0f;
  localparam logic [7:0]  SUB_SYNC_MAX = 8'h11;
  localparam logic [7:0]  SUB_COPY_T   = 8'h12;
  localparam logic [7:0]  SUB_COPY_MAX = 8'h14;
  localparam logic [7:0]  SUB_OUT_MISS = 8'h15;
  localparam logic [7:0]  SUB_IN_MISS  = 8'h16;
  localparam logic [7:0]  SUB_SKIP     = 8'h17;
  localparam logic [7:0]  SUB_RX_TOTAL = 8'h18;
  localparam logic [7:0]  SUB_TX_TOTAL = 8'h19;
  localparam logic [7:0]  SUB_GAP      = 8'h1a;
  localparam logic [7:0]  SUB_CTRL_HDR = 8'h00;
  localparam logic [7:0]  SUB_AUTO     = 8'h01;

  // ****************************************
  // Control process data
  // ****************************************
  localparam logic [7:0]  CTRL_PDO_NUM   = 8'h86;
  localparam int          CTRL_AUTO_BIT  = 0;
  localparam logic [7:0]  CTRL_HDR_VALUE = 8'h01;
  localparam logic        AUTO_RESET_VAL = 1'b0;

  // ****************************************
  // Counters
  // ****************************************
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [31:0] TIME_MAX     = 32'hffffffff;
  localparam int          CNT_OUT_MISS = 0;
  localparam int          CNT_IN_MISS  = 1;
  localparam int          CNT_SKIP     = 2;
  localparam int          CNT_RX_TOTAL = 3;
  localparam int          CNT_TX_TOTAL = 4;
  localparam int          NUM_CNT      = 5;

  typedef enum logic {CYC_IDLE, CYC_BUSY} cyc_state_t;

endpackage

/* File: hdl/sat_count16.sv */
// Saturating 16-bit accumulator
`timescale 1ns/1ps
`default_nettype none
module sat_count16
  import can_diag_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_add,
  output logic      [15:0] o_value
);

  typedef struct packed {
    logic [15:0] value;
  } cnt_state_t;

  cnt_state_t  state_r;
  cnt_state_t  state_nxt;
  logic [16:0] sum;

  always_comb begin
    state_nxt = state_r;
    sum       = {1'b0, state_r.value} + {9'h000, i_add};
    if (sum > {1'b0, CNT_MAX}) begin
      state_nxt.value = CNT_MAX;
    end else begin
      state_nxt.value = sum[15:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_value = state_r.value;

endmodule // sat_count16
`default_nettype wire

/* File: hdl/time_meter.sv */
// Elapsed-time meter in nanoseconds with current and maximum capture
`timescale 1ns/1ps
`default_nettype none
module time_meter
  import can_diag_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  output logic      [31:0] o_current,
  output logic      [31:0] o_maximum
);

  typedef struct packed {
    logic        running;
    logic [31:0] elapsed;
    logic [31:0] current;
    logic [31:0] maximum;
  } meter_state_t;

  meter_state_t state_r;
  meter_state_t state_nxt;
  logic [32:0]  sum;

  always_comb begin
    state_nxt = state_r;
    sum       = {1'b0, state_r.elapsed} + {1'b0, NS_PER_CYCLE};
    if (state_r.running) begin
      state_nxt.elapsed = sum[32] ? TIME_MAX : sum[31:0];
    end
    // Stop captures time up to this edge
    if (i_stop && state_r.running) begin
      state_nxt.running = 1'b0;
      state_nxt.current = state_r.elapsed;
      if (state_r.elapsed > state_r.maximum) begin
        state_nxt.maximum = state_r.elapsed;
      end
    end
    // Start restarts the measurement
    if (i_start) begin
      state_nxt.running = 1'b1;
      state_nxt.elapsed = NS_PER_CYCLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_current = state_r.current;
  assign o_maximum = state_r.maximum;

endmodule // time_meter
`default_nettype wire

/* File: hdl/can_cycle_diagnostics.sv */
// CAN cycle diagnostics: cycle timing, failure counters, error totals, control
//
// Operation
// - Record per cycle the ns from cycle start until SYNC ready.
// - Hold the largest cycle-start-to-SYNC delay as 32-bit read-only value.
// - Record ns from input shift time until host inputs fully written.
// - Keep the largest input shift to inputs-written time.
// - Count cycles whose host output data were not taken over.
// - Count cycles whose host input data were not gathered.
// - Skip the next cycle when the current one is unfinished; count skips.
// - Accumulate receive errors from the controller receive error count.
// - Accumulate transmit errors from the controller transmit error count.
// - Control bits come from receive process data object 134 only.
// - With auto-reset set, a bus-off controller is returned to bus-on.
// - Report controller receive and transmit error counts as 8-bit entries.
`timescale 1ns/1ps
`default_nettype none
module can_cycle_diagnostics
  import can_diag_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Cycle events from the CAN master logic, same clock
  input  wire logic        i_cycle_start,
  input  wire logic        i_cycle_end,
  input  wire logic        i_sync_ready,
  input  wire logic        i_input_shift,
  input  wire logic        i_inputs_written,
  input  wire logic        i_output_miss,
  input  wire logic        i_input_miss,
  output logic             o_cycle_go,
  output logic             o_cycle_skip,
  // CAN controller status
  input  wire logic [7:0]  i_rx_err_cnt,
  input  wire logic [7:0]  i_tx_err_cnt,
  input  wire logic        i_bus_off,
  output logic             o_bus_on_req,
  // Receive process data
  input  wire logic        i_pdo_strobe,
  input  wire logic [7:0]  i_pdo_number,
  input  wire logic [7:0]  i_pdo_control,
  // Object access
  input  wire logic        i_obj_req,
  input  wire logic        i_obj_write,
  input  wire logic [15:0] i_obj_index,
  input  wire logic [7:0]  i_obj_sub,
  output logic             o_obj_ack,
  output logic             o_obj_err,
  output logic      [31:0] o_obj_rdata
);

  // ****************************************
  // Object decode
  // ****************************************
  function automatic logic obj_hit(input logic [15:0] idx, input logic [7:0] sub);
    logic hit;
    hit = 1'b0;
    case (idx)
      IDX_STATUS: hit = (sub == SUB_RX_CNT) || (sub == SUB_TX_CNT);
      IDX_DIAG:   hit = (sub == SUB_SYNC_T) || (sub == SUB_SYNC_MAX) ||
                        (sub == SUB_COPY_T) || (sub == SUB_COPY_MAX) ||
                        ((sub >= SUB_OUT_MISS) && (sub <= SUB_GAP));
      IDX_CTRL:   hit = (sub == SUB_CTRL_HDR) || (sub == SUB_AUTO);
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cyc_state_t  cyc;
    logic        cycle_go;
    logic        cycle_skip;
    logic [7:0]  rx_cnt;
    logic [7:0]  tx_cnt;
    logic        auto_recover;
    logic        recover_sent;
    logic        bus_on_req;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } diag_state_t;

  diag_state_t state_r;
  diag_state_t state_nxt;

  logic        acc_start;
  logic        skip_evt;
  logic [7:0]  rx_delta;
  logic [7:0]  tx_delta;
  logic [7:0]  cnt_add [NUM_CNT];
  logic [15:0] cnt_val [NUM_CNT];
  logic [31:0] sync_ready_time;
  logic [31:0] sync_ready_time_max;
  logic [31:0] input_copy_time;
  logic [31:0] input_copy_time_max;
  logic [31:0] rd_word;

  // ****************************************
  // Cycle sequencing and counter increments
  // ****************************************
  always_comb begin
    // A cycle ending this edge lets a new one start in time
    acc_start = i_cycle_start && ((state_r.cyc == CYC_IDLE) || i_cycle_end);
    skip_evt  = i_cycle_start && !acc_start;
    rx_delta  = (i_rx_err_cnt > state_r.rx_cnt) ? (i_rx_err_cnt - state_r.rx_cnt) : 8'h00;
    tx_delta  = (i_tx_err_cnt > state_r.tx_cnt) ? (i_tx_err_cnt - state_r.tx_cnt) : 8'h00;
    cnt_add[CNT_OUT_MISS] = {7'h00, i_output_miss};
    cnt_add[CNT_IN_MISS]  = {7'h00, i_input_miss};
    cnt_add[CNT_SKIP]     = {7'h00, skip_evt};
    cnt_add[CNT_RX_TOTAL] = rx_delta;
    cnt_add[CNT_TX_TOTAL] = tx_delta;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      sat_count16 u_cnt (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_add   (cnt_add[g]),
        .o_value (cnt_val[g])
      );
    end
  endgenerate

  // ****************************************
  // Time measurements
  // ****************************************
  time_meter u_sync_meter (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_start   (acc_start),
    .i_stop    (i_sync_ready),
    .o_current (sync_ready_time),
    .o_maximum (sync_ready_time_max)
  );

  time_meter u_copy_meter (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_start   (i_input_shift),
    .i_stop    (i_inputs_written),
    .o_current (input_copy_time),
    .o_maximum (input_copy_time_max)
  );

  // ****************************************
  // Read data selection
  // ****************************************
  always_comb begin
    rd_word = 32'h00000000;
    case (i_obj_index)
      IDX_STATUS: begin
        case (i_obj_sub)
          SUB_RX_CNT: rd_word = {24'h000000, state_r.rx_cnt};
          SUB_TX_CNT: rd_word = {24'h000000, state_r.tx_cnt};
          default:    rd_word = 32'h00000000;
        endcase
      end
      IDX_DIAG: begin
        case (i_obj_sub)
          SUB_SYNC_T:   rd_word = sync_ready_time;
          SUB_SYNC_MAX: rd_word = sync_ready_time_max;
          SUB_COPY_T:   rd_word = input_copy_time;
          SUB_COPY_MAX: rd_word = input_copy_time_max;
          SUB_OUT_MISS: rd_word = {16'h0000, cnt_val[CNT_OUT_MISS]};
          SUB_IN_MISS:  rd_word = {16'h0000, cnt_val[CNT_IN_MISS]};
          SUB_SKIP:     rd_word = {16'h0000, cnt_val[CNT_SKIP]};
          SUB_RX_TOTAL: rd_word = {16'h0000, cnt_val[CNT_RX_TOTAL]};
          SUB_TX_TOTAL: rd_word = {16'h0000, cnt_val[CNT_TX_TOTAL]};
          default:      rd_word = 32'h00000000;
        endcase
      end
      IDX_CTRL: begin
        case (i_obj_sub)
          SUB_CTRL_HDR: rd_word = {24'h000000, CTRL_HDR_VALUE};
          SUB_AUTO:     rd_word = {31'h00000000, state_r.auto_recover};
          default:      rd_word = 32'h00000000;
        endcase
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt            = state_r;
    state_nxt.cycle_go   = acc_start;
    state_nxt.cycle_skip = skip_evt;
    case (state_r.cyc)
      CYC_IDLE: begin
        if (acc_start) begin
          state_nxt.cyc = CYC_BUSY;
        end
      end
      CYC_BUSY: begin
        if (i_cycle_end && !acc_start) begin
          state_nxt.cyc = CYC_IDLE;
        end
      end
      default: state_nxt.cyc = CYC_IDLE;
    endcase
    state_nxt.rx_cnt = i_rx_err_cnt;
    state_nxt.tx_cnt = i_tx_err_cnt;
    // Control byte only from its own process data object
    if (i_pdo_strobe && (i_pdo_number == CTRL_PDO_NUM)) begin
      state_nxt.auto_recover = i_pdo_control[CTRL_AUTO_BIT];
    end
    // One bus-on request per bus-off episode
    state_nxt.bus_on_req   = state_r.auto_recover && i_bus_off && !state_r.recover_sent;
    state_nxt.recover_sent = i_bus_off && (state_r.recover_sent || state_nxt.bus_on_req);
    state_nxt.ack   = i_obj_req;
    state_nxt.err   = i_obj_req && (i_obj_write || !obj_hit(i_obj_index, i_obj_sub));
    if (i_obj_req) begin
      state_nxt.rdata = (i_obj_write || !obj_hit(i_obj_index, i_obj_sub)) ? 32'h00000000 : rd_word;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r              <= '0;
      state_r.cyc          <= CYC_IDLE;
      state_r.auto_recover <= AUTO_RESET_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_cycle_go   = state_r.cycle_go;
  assign o_cycle_skip = state_r.cycle_skip;
  assign o_bus_on_req = state_r.bus_on_req;
  assign o_obj_ack    = state_r.ack;
  assign o_obj_err    = state_r.err;
  assign o_obj_rdata  = state_r.rdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_sync_three;
    acc_start ##1 (!i_sync_ready && !acc_start)[*2] ##1 i_sync_ready;
  endsequence

  sequence s_copy_two;
    i_input_shift ##1 (!i_inputs_written && !i_input_shift) ##1 i_inputs_written;
  endsequence

  sync_time_a: assert property (s_sync_three |=> sync_ready_time == 32'(3 * NS_PER_CYCLE))
    else $error("sync ready time wrong");

  sync_max_a: assert property (sync_ready_time_max >= $past(sync_ready_time_max) &&
                               sync_ready_time_max >= sync_ready_time)
    else $error("sync ready max not held");

  copy_time_a: assert property (s_copy_two |=> input_copy_time == 32'(2 * NS_PER_CYCLE))
    else $error("input copy time wrong");

  copy_max_a: assert property (s_copy_two ##1 (input_copy_time > $past(input_copy_time_max))
                               |-> input_copy_time_max == input_copy_time)
    else $error("input copy max not raised");

  out_miss_a: assert property (i_output_miss && cnt_val[CNT_OUT_MISS] != CNT_MAX
                               |=> cnt_val[CNT_OUT_MISS] == $past(cnt_val[CNT_OUT_MISS]) + 16'h0001)
    else $error("output miss count wrong");

  in_miss_a: assert property (i_input_miss && cnt_val[CNT_IN_MISS] != CNT_MAX
                              |=> cnt_val[CNT_IN_MISS] == $past(cnt_val[CNT_IN_MISS]) + 16'h0001)
    else $error("input miss count wrong");

  cycle_skip_a: assert property (state_r.cyc == CYC_BUSY && i_cycle_start && !i_cycle_end
                                 |=> o_cycle_skip && !o_cycle_go)
    else $error("busy cycle not skipped");

  rx_total_a: assert property ((i_rx_err_cnt > state_r.rx_cnt) &&
                               ({1'b0, cnt_val[CNT_RX_TOTAL]} + {9'h000, rx_delta} <= {1'b0, CNT_MAX})
                               |=> cnt_val[CNT_RX_TOTAL] == $past(cnt_val[CNT_RX_TOTAL]) + {8'h00, $past(rx_delta)})
    else $error("receive error total wrong");

  tx_total_a: assert property ((i_tx_err_cnt > state_r.tx_cnt) &&
                               ({1'b0, cnt_val[CNT_TX_TOTAL]} + {9'h000, tx_delta} <= {1'b0, CNT_MAX})
                               |=> cnt_val[CNT_TX_TOTAL] == $past(cnt_val[CNT_TX_TOTAL]) + {8'h00, $past(tx_delta)})
    else $error("transmit error total wrong");

  ctrl_pdo_a: assert property (i_pdo_strobe && i_pdo_number == CTRL_PDO_NUM
                               |=> state_r.auto_recover == $past(i_pdo_control[CTRL_AUTO_BIT]))
    else $error("control bit not taken");

  bus_on_a: assert property (state_r.auto_recover && i_bus_off && !state_r.recover_sent
                             |=> o_bus_on_req ##1 !o_bus_on_req)
    else $error("bus-on request wrong");

  err_cnt_a: assert property (##1 o_obj_ack && !o_obj_err && $past(i_obj_index) == IDX_STATUS &&
                              $past(i_obj_sub) == SUB_RX_CNT |-> o_obj_rdata == {24'h000000, $past(i_rx_err_cnt, 2)})
    else $error("receive error count read wrong");

  saturate_a: assert property (cnt_val[CNT_TX_TOTAL] == CNT_MAX |=> cnt_val[CNT_TX_TOTAL] == CNT_MAX)
    else $error("transmit total wrapped");

endmodule // can_cycle_diagnostics
`default_nettype wire

/* File: testbench/can_ctrl_model.sv */
// Behavioural CAN controller facing the diagnostics block
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_rx_val,
  input  wire logic [7:0] i_tx_val,
  input  wire logic       i_go_bus_off,
  input  wire logic       i_bus_on_req,
  output logic      [7:0] o_rx_err_cnt,
  output logic      [7:0] o_tx_err_cnt,
  output logic            o_bus_off
);
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rx_err_cnt <= 8'h00;
      o_tx_err_cnt <= 8'h00;
      o_bus_off    <= 1'b0;
    end else begin
      if (i_load) begin
        o_rx_err_cnt <= i_rx_val;
        o_tx_err_cnt <= i_tx_val;
      end
      if (i_go_bus_off) begin
        o_bus_off <= 1'b1;
      end else if (i_bus_on_req) begin
        // Bus-on restarts the error counters
        o_bus_off    <= 1'b0;
        o_rx_err_cnt <= 8'h00;
        o_tx_err_cnt <= 8'h00;
      end
    end
  end
endmodule // can_ctrl_model
`default_nettype wire

/* File: testbench/test_can_cycle_diagnostics.sv */
// Self-checking bench for the CAN cycle diagnostics block
`timescale 1ns/1ps
`default_nettype none
module test_can_cycle_diagnostics
  import can_diag_pkg::*;
();
  localparam logic [6:0] EV_START = 7'h01;
  localparam logic [6:0] EV_END   = 7'h02;
  localparam logic [6:0] EV_SYNC  = 7'h04;
  localparam logic [6:0] EV_SHIFT = 7'h08;
  localparam logic [6:0] EV_WR    = 7'h10;
  localparam logic [6:0] EV_OMISS = 7'h20;
  localparam logic [6:0] EV_IMISS = 7'h40;
  localparam logic [7:0] SUBS [10] = '{SUB_SYNC_T, SUB_SYNC_MAX, SUB_COPY_T, SUB_COPY_MAX, SUB_OUT_MISS,
                                       SUB_IN_MISS, SUB_SKIP, SUB_RX_TOTAL, SUB_TX_TOTAL, SUB_GAP};

  logic        clock, nrst, ld, go_off, bus_off, pdo_stb, req, wr;
  logic        cycle_go, cycle_skip, bus_on_req, ack, err;
  logic [6:0]  ev;
  logic [7:0]  rx_val, tx_val, rx_cnt, tx_cnt, pdo_num, pdo_ctl, sub;
  logic [15:0] idx;
  logic [31:0] rdata;
  int          n_errors, n_compared, n_go, n_skip, n_bus_on;

  can_cycle_diagnostics can_cycle_diagnostics_inst (
    .i_clock(clock), .i_nrst(nrst), .i_cycle_start(ev[0]), .i_cycle_end(ev[1]), .i_sync_ready(ev[2]),
    .i_input_shift(ev[3]), .i_inputs_written(ev[4]), .i_output_miss(ev[5]), .i_input_miss(ev[6]),
    .o_cycle_go(cycle_go), .o_cycle_skip(cycle_skip), .i_rx_err_cnt(rx_cnt), .i_tx_err_cnt(tx_cnt),
    .i_bus_off(bus_off), .o_bus_on_req(bus_on_req), .i_pdo_strobe(pdo_stb), .i_pdo_number(pdo_num),
    .i_pdo_control(pdo_ctl), .i_obj_req(req), .i_obj_write(wr), .i_obj_index(idx), .i_obj_sub(sub),
    .o_obj_ack(ack), .o_obj_err(err), .o_obj_rdata(rdata));

  can_ctrl_model can_ctrl_model_inst (
    .i_clock(clock), .i_nrst(nrst), .i_load(ld), .i_rx_val(rx_val), .i_tx_val(tx_val),
    .i_go_bus_off(go_off), .i_bus_on_req(bus_on_req), .o_rx_err_cnt(rx_cnt), .o_tx_err_cnt(tx_cnt),
    .o_bus_off(bus_off));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Pulse watcher for single-cycle outputs
  always @(posedge clock) begin
    if (cycle_go === 1'b1) n_go++;
    if (cycle_skip === 1'b1) n_skip++;
    if (bus_on_req === 1'b1) n_bus_on++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic fail(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic step(input logic [6:0] m);
    ev = m;
    @(posedge clock);
    #1;
  endtask

  task automatic gap(input int n);
    repeat (n) step(7'h00);
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) fail($sformatf("%s is %h, expected %h", what, got, exp));
  endtask

  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic w, input logic e_err,
                     input logic [31:0] e_data);
    int k;
    req = 1'b1;
    wr = w;
    idx = i;
    sub = s;
    gap(1);
    k = 0;
    while (ack !== 1'b1 && k < 4) begin
      gap(1);
      k++;
    end
    n_compared++;
    if (ack !== 1'b1 || err !== e_err || rdata !== e_data) begin
      fail($sformatf("object %h:%h ack %b err %b data %h", i, s, ack, err, rdata));
    end
    // Let an edge pass so a following request is a fresh strobe
    req = 1'b0;
    gap(1);
  endtask

  task automatic run_cycle(input int sg, input int cg);
    step(EV_START);
    gap(sg);
    step(EV_SYNC);
    step(EV_SHIFT);
    gap(cg);
    step(EV_WR);
    step(EV_END);
    gap(2);
  endtask

  task automatic set_err(input logic [7:0] r, input logic [7:0] t);
    rx_val = r;
    tx_val = t;
    ld = 1'b1;
    gap(1);
    ld = 1'b0;
    gap(1);
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clock);
    fail("timeout");
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {ev, ld, rx_val, tx_val, go_off, pdo_stb, pdo_num, pdo_ctl, req, wr, idx, sub} = '0;
    nrst = 1'b0;
    gap(10);
    nrst = 1'b1;
    gap(1);
    for (int j = 0; j < 10; j++) obj(IDX_DIAG, SUBS[j], 1'b0, 1'b0, 32'h0);
    obj(IDX_CTRL, SUB_CTRL_HDR, 1'b0, 1'b0, {24'h0, CTRL_HDR_VALUE});
    obj(IDX_CTRL, SUB_AUTO, 1'b1, 1'b1, 32'h0);
    obj(IDX_CTRL, SUB_AUTO, 1'b0, 1'b0, 32'h0);
    obj(IDX_DIAG, SUB_SYNC_MAX, 1'b1, 1'b1, 32'h0);
    obj(IDX_DIAG, 8'h00, 1'b0, 1'b1, 32'h0);
    run_cycle(2, 4);
    obj(IDX_DIAG, SUB_SYNC_T, 1'b0, 1'b0, 3 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_SYNC_MAX, 1'b0, 1'b0, 3 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_COPY_T, 1'b0, 1'b0, 5 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_COPY_MAX, 1'b0, 1'b0, 5 * NS_PER_CYCLE);
    run_cycle(0, 6);
    obj(IDX_DIAG, SUB_SYNC_T, 1'b0, 1'b0, 1 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_SYNC_MAX, 1'b0, 1'b0, 3 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_COPY_T, 1'b0, 1'b0, 7 * NS_PER_CYCLE);
    obj(IDX_DIAG, SUB_COPY_MAX, 1'b0, 1'b0, 7 * NS_PER_CYCLE);
    step(EV_START);
    gap(1);
    step(EV_START);
    step(EV_START | EV_END);
    step(EV_END);
    gap(2);
    check_val(32'(n_skip), 32'd1, "skip pulses");
    check_val(32'(n_go), 32'd4, "accepted cycles");
    obj(IDX_DIAG, SUB_SKIP, 1'b0, 1'b0, 32'h1);
    repeat (2) step(EV_OMISS | EV_IMISS);
    step(EV_OMISS);
    gap(2);
    obj(IDX_DIAG, SUB_OUT_MISS, 1'b0, 1'b0, 32'h3);
    obj(IDX_DIAG, SUB_IN_MISS, 1'b0, 1'b0, 32'h2);
    set_err(8'h05, 8'h00);
    set_err(8'h03, 8'h00);
    set_err(8'h0a, 8'h00);
    gap(2);
    obj(IDX_STATUS, SUB_RX_CNT, 1'b0, 1'b0, 32'h0a);
    obj(IDX_DIAG, SUB_RX_TOTAL, 1'b0, 1'b0, 32'h0c);
    repeat (258) begin
      set_err(8'h0a, 8'hff);
      set_err(8'h0a, 8'h00);
    end
    set_err(8'h0a, 8'h09);
    gap(2);
    obj(IDX_STATUS, SUB_TX_CNT, 1'b0, 1'b0, 32'h09);
    obj(IDX_DIAG, SUB_TX_TOTAL, 1'b0, 1'b0, {16'h0, CNT_MAX});
    go_off = 1'b1;
    gap(1);
    go_off = 1'b0;
    gap(3);
    pdo_num = 8'h85;
    pdo_ctl = 8'h01;
    pdo_stb = 1'b1;
    gap(1);
    pdo_stb = 1'b0;
    gap(3);
    check_val(32'(n_bus_on), 32'd0, "bus-on requests");
    obj(IDX_CTRL, SUB_AUTO, 1'b0, 1'b0, 32'h0);
    pdo_num = 8'h86;
    pdo_stb = 1'b1;
    gap(1);
    pdo_stb = 1'b0;
    gap(4);
    check_val(32'(n_bus_on), 32'd1, "bus-on requests");
    check_val({31'h0, bus_off}, 32'h0, "bus-off level");
    obj(IDX_CTRL, SUB_AUTO, 1'b0, 1'b0, 32'h1);
    obj(IDX_DIAG, SUB_RX_TOTAL, 1'b0, 1'b0, 32'h0c);
    go_off = 1'b1;
    gap(1);
    go_off = 1'b0;
    gap(4);
    check_val(32'(n_bus_on), 32'd2, "bus-on requests");
    end_of_test();
  end
endmodule // test_can_cycle_diagnostics
`default_nettype wire
